// ==== inc/scp_pkg.sv ====
package cwp_pkg;
  // ************************************************************
  // Word layout, edge count, serial mode and synchroniser depth
  // ************************************************************
  localparam int          WORD_W       = 9;
  localparam int          CNT_W        = 4;
  localparam logic [3:0]  LAST_EDGE    = 4'h9;
  localparam int          START_POS    = 8;
  localparam int          BIPOLAR_POS  = 7;
  localparam int          SPAN_POS     = 6;
  localparam int          PWR_DOWN_POS = 5;
  localparam int          CODING_POS   = 2;
  localparam logic [8:0]  CFG_RESET    = 9'h000;
  localparam logic [8:0]  WRITE_MASK   = 9'h1fc;
  localparam logic [1:0]  SERIAL_MODE  = 2'h3;
  localparam int          SYNC_STAGES  = 2;
endpackage

// ==== src/scp_sync.sv ====
`timescale 1ns/1ps
module cwp_sync
  import cwp_pkg::*;
#(
  parameter int STAGES = SYNC_STAGES
) (
  // Clock and reset.
  input  wire logic sys_clk,
  input  wire logic reset_n,
  // Level in and out.
  input  wire logic din,
  output logic      dout
);
  logic [STAGES-1:0] sync_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_q <= '0;
    end else begin
      sync_q <= {sync_q[STAGES-2:0], din};
    end
  end

  assign dout = sync_q[STAGES-1];
endmodule

// ==== src/scp_config_port.sv ====
`timescale 1ns/1ps
module cwp_config_port
  import cwp_pkg::*;
(
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // Shared data pins D[17:14] in configuration use.
  input  wire logic       config_source_select,
  input  wire logic       cfg_serial_clock,
  input  wire logic       cfg_serial_in,
  input  wire logic       cfg_select_n,
  // Mode straps.
  input  wire logic [1:0] mode,
  input  wire logic       clock_invert,
  // Settings applied to the converter.
  output logic [8:0]      configuration_word,
  output logic [1:0]      input_range,
  output logic            power_down_bit,
  output logic            output_coding_sel,
  output logic            cfg_update
);
  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic       clk_s, din_s, sel_s, src_s, inv_s;
  logic [1:0] mode_s;

  cwp_sync u_clk (.sys_clk(sys_clk), .reset_n(reset_n), .din(cfg_serial_clock), .dout(clk_s));
  cwp_sync u_din (.sys_clk(sys_clk), .reset_n(reset_n), .din(cfg_serial_in), .dout(din_s));
  cwp_sync u_sel (.sys_clk(sys_clk), .reset_n(reset_n), .din(~cfg_select_n), .dout(sel_s));
  cwp_sync u_src (.sys_clk(sys_clk), .reset_n(reset_n), .din(config_source_select), .dout(src_s));
  cwp_sync u_inv (.sys_clk(sys_clk), .reset_n(reset_n), .din(clock_invert), .dout(inv_s));
  cwp_sync u_mode0 (.sys_clk(sys_clk), .reset_n(reset_n), .din(mode[0]), .dout(mode_s[0]));
  cwp_sync u_mode1 (.sys_clk(sys_clk), .reset_n(reset_n), .din(mode[1]), .dout(mode_s[1]));

  // ************************************************************
  // Edge detection and enable
  // ************************************************************
  logic            clk_prev_q;
  logic            selected;
  logic            port_enable;
  logic            rise;
  logic            fall;
  logic            active_edge;
  logic [8:0]      shift_q, shift_d;
  logic [CNT_W-1:0] count_q, count_d;
  logic [8:0]      cfg_q, cfg_d;
  logic            upd_q;
  logic            loading;
  logic            start_ok;
  logic            commit;

  assign selected    = sel_s;
  assign port_enable = (mode_s == SERIAL_MODE) && !src_s;
  assign rise        = clk_s && !clk_prev_q;
  assign fall        = !clk_s && clk_prev_q;
  assign active_edge = inv_s ? fall : rise;
  assign loading     = count_q != '0;
  assign start_ok    = loading || din_s;
  assign commit      = port_enable && selected && active_edge && start_ok
                       && (count_q == LAST_EDGE - 4'h1);

  // ************************************************************
  // Shift and count
  // ************************************************************
  always_comb begin
    shift_d = shift_q;
    count_d = count_q;
    if (!selected || !port_enable) begin
      count_d = '0;
    end else if (active_edge && start_ok) begin
      shift_d = {shift_q[WORD_W-2:0], din_s};
      count_d = commit ? '0 : count_q + 4'h1;
    end
  end

  assign cfg_d = commit ? (({shift_q[WORD_W-2:0], din_s} & WRITE_MASK) | (cfg_q & ~WRITE_MASK))
                        : cfg_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_prev_q <= 1'b0;
      shift_q    <= CFG_RESET;
      count_q    <= '0;
      cfg_q      <= CFG_RESET;
      upd_q      <= 1'b0;
    end else begin
      clk_prev_q <= clk_s;
      shift_q    <= shift_d;
      count_q    <= count_d;
      cfg_q      <= cfg_d;
      upd_q      <= commit;
    end
  end

  // ************************************************************
  // Decoded settings
  // ************************************************************
  assign configuration_word = cfg_q;
  assign input_range        = {cfg_q[BIPOLAR_POS], cfg_q[SPAN_POS]};
  assign power_down_bit     = cfg_q[PWR_DOWN_POS];
  assign output_coding_sel  = cfg_q[CODING_POS];
  assign cfg_update         = upd_q;

  // ************************************************************
  // Checks
  // ************************************************************
  property p_reserved_hold;
    @(posedge sys_clk) disable iff (!reset_n)
    1'b1 |=> cfg_q[1:0] == $past(cfg_q[1:0]);
  endproperty
  a_reserved_hold: assert property (p_reserved_hold) else $error("reserved bits changed");

  property p_commit_only_enabled;
    @(posedge sys_clk) disable iff (!reset_n)
    !port_enable |=> count_q == '0 && $stable(cfg_q);
  endproperty
  a_commit_only_enabled: assert property (p_commit_only_enabled) else $error("commit while disabled");

  property p_cfg_stable_no_commit;
    @(posedge sys_clk) disable iff (!reset_n)
    !commit |=> $stable(cfg_q);
  endproperty
  a_cfg_stable_no_commit: assert property (p_cfg_stable_no_commit) else $error("config changed without commit");

  property p_update_pulse;
    @(posedge sys_clk) disable iff (!reset_n)
    commit |=> cfg_update ##1 !cfg_update;
  endproperty
  a_update_pulse: assert property (p_update_pulse) else $error("update pulse wrong");

  property p_count_clear_deselect;
    @(posedge sys_clk) disable iff (!reset_n)
    !selected |=> count_q == '0;
  endproperty
  a_count_clear_deselect: assert property (p_count_clear_deselect) else $error("count kept after deselect");

  property p_start_needed;
    @(posedge sys_clk) disable iff (!reset_n)
    (count_q == '0 && active_edge && !din_s) |=> count_q == '0;
  endproperty
  a_start_needed: assert property (p_start_needed) else $error("load began without start");

  property p_count_range;
    @(posedge sys_clk) disable iff (!reset_n)
    count_q < LAST_EDGE;
  endproperty
  a_count_range: assert property (p_count_range) else $error("count overran");

  property p_coding_out;
    @(posedge sys_clk) disable iff (!reset_n)
    commit |=> output_coding_sel == $past(shift_q[CODING_POS-1]);
  endproperty
  a_coding_out: assert property (p_coding_out) else $error("coding select wrong");

  property p_msb_commit;
    @(posedge sys_clk) disable iff (!reset_n)
    commit |=> cfg_q[WORD_W-1:CODING_POS] == $past(shift_q[WORD_W-2:CODING_POS-1]);
  endproperty
  a_msb_commit: assert property (p_msb_commit) else $error("committed word wrong");

  property p_range_out;
    @(posedge sys_clk) disable iff (!reset_n)
    commit |=> input_range == $past(shift_q[BIPOLAR_POS-1:SPAN_POS-1]);
  endproperty
  a_range_out: assert property (p_range_out) else $error("input range wrong");

  property p_power_down_out;
    @(posedge sys_clk) disable iff (!reset_n)
    commit |=> power_down_bit == $past(shift_q[PWR_DOWN_POS-1]);
  endproperty
  a_power_down_out: assert property (p_power_down_out) else $error("power down wrong");

  property p_start_kept;
    @(posedge sys_clk) disable iff (!reset_n)
    commit |=> cfg_q[START_POS];
  endproperty
  a_start_kept: assert property (p_start_kept) else $error("start bit not stored");

  property p_load_begin;
    @(posedge sys_clk) disable iff (!reset_n)
    (count_q == '0 && port_enable && selected && active_edge && din_s) |=> count_q == CNT_W'(1);
  endproperty
  a_load_begin: assert property (p_load_begin) else $error("load did not begin");

  property p_update_from_commit;
    @(posedge sys_clk) disable iff (!reset_n)
    cfg_update |-> $past(commit);
  endproperty
  a_update_from_commit: assert property (p_update_from_commit) else $error("update without commit");

  property p_reset_clear;
    @(posedge sys_clk)
    !reset_n ##1 !reset_n |-> cfg_q == CFG_RESET && !cfg_update;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset did not clear");

  c_commit:     cover property (@(posedge sys_clk) commit);
  c_abort:      cover property (@(posedge sys_clk) loading ##1 !selected);
  c_inverted:   cover property (@(posedge sys_clk) commit && inv_s);
  c_power_down: cover property (@(posedge sys_clk) commit ##1 power_down_bit);
  c_no_start:   cover property (@(posedge sys_clk) selected && !loading && active_edge && !din_s);
endmodule

// ==== tb/scp_host_model.sv ====
`timescale 1ns/1ps
// ****************************************
// Host that drives the configuration pins.
// ****************************************
module cwp_host_model (
  // Pins toward the port.
  output logic      cfg_serial_clock,
  output logic      cfg_serial_in,
  output logic      cfg_select_n,
  // Active edge choice.
  input  wire logic clock_invert
);
  initial begin
    cfg_select_n     = 1'b1;
    cfg_serial_in    = 1'b0;
    cfg_serial_clock = 1'b0;
  end
  // Sends the top n bits of w at 12.5 MHz; the clock stands still between frames.
  task automatic send(input logic [8:0] w, input int n);
    cfg_serial_clock = clock_invert;
    cfg_select_n     = 1'b0;
    for (int i = 8; i > 8 - n; i--) begin
      cfg_serial_in = w[i];
      #40 cfg_serial_clock = ~cfg_serial_clock;
      #40 cfg_serial_clock = ~cfg_serial_clock;
    end
    #40 cfg_select_n = 1'b1;
    cfg_serial_in = ~cfg_serial_in;
  endtask
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
// ****************************************
// Bench for the configuration port.
// ****************************************
module tb_top;
  import cwp_pkg::*;
  logic       sys_clk              = 1'b0;
  logic       reset_n              = 1'b0;
  logic       config_source_select = 1'b0;
  logic [1:0] mode                 = SERIAL_MODE;
  logic       clock_invert         = 1'b0;
  logic       cfg_serial_clock, cfg_serial_in, cfg_select_n;
  logic       power_down_bit, output_coding_sel, cfg_update;
  logic [8:0] configuration_word;
  logic [1:0] input_range;
  logic [8:0] cur                  = 9'h000;
  int         err_count            = 0;
  int         checks               = 0;
  int         upd                  = 0;
  always #5 sys_clk = ~sys_clk;
  always @(negedge sys_clk) if (cfg_update === 1'b1) upd++;
  cwp_config_port u_cwp_config_port (.sys_clk(sys_clk), .reset_n(reset_n),
    .config_source_select(config_source_select), .cfg_serial_clock(cfg_serial_clock),
    .cfg_serial_in(cfg_serial_in), .cfg_select_n(cfg_select_n), .mode(mode),
    .clock_invert(clock_invert), .configuration_word(configuration_word),
    .input_range(input_range), .power_down_bit(power_down_bit),
    .output_coding_sel(output_coding_sel), .cfg_update(cfg_update));
  cwp_host_model u_cwp_host_model (.cfg_serial_clock(cfg_serial_clock), .cfg_serial_in(cfg_serial_in),
    .cfg_select_n(cfg_select_n), .clock_invert(clock_invert));
  task end_sim;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [8:0] got, input logic [8:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Writes n bits, then checks commit count, word and decoded settings.
  task wr(input logic [8:0] w, input int n, input logic ok);
    @(posedge sys_clk) #1 upd = 0;
    u_cwp_host_model.send(w, n);
    repeat (40) @(negedge sys_clk);
    if (ok) cur = {w[8:2], cur[1:0]};
    chk(9'(upd), {8'h00, ok});
    chk(configuration_word, cur);
    chk({7'h00, input_range}, {7'h00, cur[7:6]});
    chk({7'h00, power_down_bit, output_coding_sel}, {7'h00, cur[5], cur[2]});
    $display("write %h bits %0d done", w, n);
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    chk(configuration_word, 9'h000);
    wr(9'h1a7, 9, 1'b1);
    for (int r = 0; r < 4; r++) wr({1'b1, r[1:0], 6'h03}, 9, 1'b1);
    wr(9'h1e4, 5, 1'b0);
    wr(9'h0ff, 9, 1'b0);
    @(posedge sys_clk) #1 mode = 2'h2;
    wr(9'h1e4, 9, 1'b0);
    @(posedge sys_clk) #1 mode = SERIAL_MODE;
    config_source_select = 1'b1;
    wr(9'h1e4, 9, 1'b0);
    @(posedge sys_clk) #1 config_source_select = 1'b0;
    clock_invert = 1'b1;
    wr(9'h124, 9, 1'b1);
    @(posedge sys_clk) #1 reset_n = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    cur = 9'h000;
    chk(configuration_word, cur);
    $display("mid-run reset done");
    wr(9'h1c4, 9, 1'b1);
    end_sim;
  end
endmodule
